// ==== src/pmc_pkg.sv ====
/*
  Package of the power mode controller: register map, field positions,
  reset values, mode encoding and the oscillator settle count.
  Assumes a single 200 MHz system clock and an APB register bus.
*/
package pmc_pkg;

  // ************************************************************
  // register map
  // ************************************************************
  localparam int PMC_ADDR_W = 12;
  localparam logic [PMC_ADDR_W-1:0] PMC_OFS_CSR = 12'h000;
  localparam logic [7:0] PMC_CSR_RESET = 8'h00;
  localparam logic [31:0] PMC_RD_ZERO = 32'h00000000;

  // ************************************************************
  // field positions in power_mode_control_status
  // ************************************************************
  localparam int PMC_BIT_PSM = 0;
  localparam int PMC_BIT_DHF = 1;
  localparam int PMC_BIT_IDLE = 2;
  localparam int PMC_BIT_HALT = 3;
  localparam int PMC_BIT_RSV = 4;
  localparam int PMC_BIT_WBPS = 5;
  localparam int PMC_BIT_HFG = 6;
  localparam int PMC_BIT_LFG = 7;

  // ************************************************************
  // main oscillator settle timer
  // ************************************************************
  localparam int PMC_TMR_W = 14;
  localparam logic [PMC_TMR_W-1:0] PMC_MAIN_GOOD_PRESET = 14'h3FFF;
  localparam logic [PMC_TMR_W-1:0] PMC_TMR_ONE = 14'h0001;
  localparam logic [PMC_TMR_W-1:0] PMC_TMR_ZERO = 14'h0000;

  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [1:0] {
    PMC_ACTIVE = 2'b00,
    PMC_PSAVE = 2'b01,
    PMC_IDLE = 2'b10,
    PMC_HALT = 2'b11
  } pmc_mode_t;

  // software-writable fields of the control/status register
  typedef struct packed {
    logic wait_before_power_save;
    logic halt_request;
    logic idle_request;
    logic hf_osc_disable;
    logic power_save_request;
  } pmc_ctrl_t;

endpackage : pmc_pkg

// ==== src/pmc_sync3.sv ====
/*
  Three-stage synchroniser with agreement filter for one level.
  Assumes the input is asynchronous to ref_clk_in.
*/
`timescale 1ns/1ps
`default_nettype none
module pmc_sync3 (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // level
  input wire logic async_in,
  output logic sync_out
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  // s1_q is read by s2_q only, to contain metastability
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      sync_out <= 1'b0;
    end else if (s2_q == s3_q) begin
      sync_out <= s3_q;
    end
  end
endmodule : pmc_sync3
`default_nettype wire

// ==== src/pmc_osc_timer.sv ====
/*
  Main oscillator settle timer: preset while the oscillator is stopped,
  counts down once it runs, and flags the clock good at zero.
  Assumes stop_in comes from a flop on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module pmc_osc_timer
  import pmc_pkg::*;
#(
  parameter logic [PMC_TMR_W-1:0] PRESET = PMC_MAIN_GOOD_PRESET
) (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // oscillator control and status
  input wire logic stop_in,
  output logic good_out
);
  logic [PMC_TMR_W-1:0] cnt_q;

  always_ff @(posedge ref_clk_in) begin
    if (rst_in || stop_in) begin
      cnt_q <= PRESET;
    end else if (cnt_q != PMC_TMR_ZERO) begin
      cnt_q <= cnt_q - PMC_TMR_ONE;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      good_out <= 1'b0;
    end else begin
      good_out <= !stop_in && (cnt_q == PMC_TMR_ZERO);
    end
  end

  a_tmr_preset: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    stop_in |=> (cnt_q == PRESET) && !good_out)
    else $error("settle timer not preset while stopped");
endmodule : pmc_osc_timer
`default_nettype wire

// ==== src/pmc_top.sv ====
/*
  Power mode controller: one byte-wide control/status register on APB,
  mode sequencing between Active, Power Save, Idle and Halt, and the
  stop signal of the main oscillator with its settle timer.
  Assumes WAIT, wake-up and interrupt acknowledge are one-cycle pulses on
  ref_clk_in, and that the slow oscillator good and crystal detect are pins.
*/
// Chosen here: the APB slave port and the placing of the registers.
// Functional notes
// - reset clears every non-reserved register bit; device starts Active
// - power_save_request zero means Active; one requests Power Save
// - software sets or clears power_save_request; wake-up clears it
// - hf_osc_disable stops oscillator only in Power Save/Idle; Halt stops always
// - wake-up clears hf_osc_disable, restarting the fast oscillator
// - idle_request enters Idle on WAIT; from Active needs wait_before_power_save
// - halt_request enters Halt on WAIT; from Active needs wait_before_power_save
// - wake-up clears idle and halt requests and returns to Active
// - without wait flag, Power Save starts at once; bit reads one when done
// - with wait flag, Power Save at next WAIT; bit reads one at once
// - hf_clock_good shows fast clock stable; Active entered only then
// - lf_clock_good is sampled selection of main or slow oscillator good
// - Active to Power Save or Idle needs lf_clock_good; Halt does not
// - Idle and Halt entered only from Active or Power Save
// - oscillator stops only after Power Save, Idle or Halt is entered
// - writing zero in Power Save returns Active; bit changes when done
// - wake-up: clear disable, wait for fast clock good, then Active
// - a transition waits while its target clock is not good
// - without slow crystal, oscillator stops only in Halt
// - without slow crystal, wake to Active on fast clock; Power Save still allowed
// - a wake-up stays latched until interrupt acknowledge or reset
// - stopping the oscillator presets a 14-bit settle timer; good at zero
`timescale 1ns/1ps
`default_nettype none
module pmc_top
  import pmc_pkg::*;
#(
  parameter logic [PMC_TMR_W-1:0] MAIN_GOOD_PRESET = PMC_MAIN_GOOD_PRESET
) (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [PMC_ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // cpu core and wake-up logic
  input wire logic wait_exec_in,
  input wire logic wake_event_in,
  input wire logic intr_ack_in,
  // dual clock module
  input wire logic slow_src_xtal_in,
  input wire logic slow_osc_good_in,
  input wire logic slow_crystal_detect_in,
  output logic stop_main_osc_out,
  // mode status
  output pmc_mode_t mode_out,
  output logic wake_pending_out
);

  // ************************************************************
  // helpers
  // ************************************************************
  // clock needed by each target mode; halt needs none
  function automatic logic clk_ok(input pmc_mode_t tgt, input logic hf, input logic lf);
    case (tgt)
      PMC_ACTIVE: clk_ok = hf;
      PMC_PSAVE: clk_ok = lf;
      PMC_IDLE: clk_ok = lf;
      default: clk_ok = 1'b1;
    endcase
  endfunction : clk_ok

  // ************************************************************
  // declarations
  // ************************************************************
  pmc_ctrl_t ctrl_q;
  pmc_mode_t mode_q;
  pmc_mode_t tgt_q;
  logic pend_q;
  logic wake_q;
  logic stop_q;
  logic hf_good_q;
  logic lf_good_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic main_good;
  logic slow_good_s;
  logic xtal_s;
  logic addr_hit;
  logic acc_done;
  logic wr_csr;
  logic redirect;
  logic complete;
  logic [7:0] csr_rd;

  // ************************************************************
  // pin inputs and settle timer
  // ************************************************************
  pmc_sync3 u_sync_slow_good (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .async_in(slow_osc_good_in),
    .sync_out(slow_good_s)
  );

  // the crystal detect pin must be tied low when no slow crystal is fitted
  pmc_sync3 u_sync_xtal (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .async_in(slow_crystal_detect_in),
    .sync_out(xtal_s)
  );

  pmc_osc_timer #(
    .PRESET(MAIN_GOOD_PRESET)
  ) u_main_timer (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .stop_in(stop_q),
    .good_out(main_good)
  );

  // ************************************************************
  // apb slave
  // ************************************************************
  assign addr_hit = (paddr_in == PMC_OFS_CSR);
  assign acc_done = psel_in && penable_in && pready_q;
  assign wr_csr = acc_done && pwrite_in && addr_hit;

  always_comb begin
    csr_rd = PMC_CSR_RESET;
    csr_rd[PMC_BIT_PSM] = ctrl_q.power_save_request;
    csr_rd[PMC_BIT_DHF] = ctrl_q.hf_osc_disable;
    csr_rd[PMC_BIT_IDLE] = ctrl_q.idle_request;
    csr_rd[PMC_BIT_HALT] = ctrl_q.halt_request;
    csr_rd[PMC_BIT_RSV] = 1'b0;
    csr_rd[PMC_BIT_WBPS] = ctrl_q.wait_before_power_save;
    csr_rd[PMC_BIT_HFG] = hf_good_q;
    csr_rd[PMC_BIT_LFG] = lf_good_q;
  end

  // one wait state: pready rises in the second access cycle
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= PMC_RD_ZERO;
    end else begin
      pready_q <= psel_in && penable_in && !pready_q;
      pslverr_q <= psel_in && penable_in && !pready_q && !addr_hit;
      if (psel_in && penable_in && !pready_q && !pwrite_in && addr_hit) begin
        prdata_q <= {24'h000000, csr_rd};
      end else begin
        prdata_q <= PMC_RD_ZERO;
      end
    end
  end

  // ************************************************************
  // clock status
  // ************************************************************
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      hf_good_q <= 1'b0;
      lf_good_q <= 1'b0;
    end else begin
      hf_good_q <= main_good;
      lf_good_q <= slow_src_xtal_in ? slow_good_s : main_good;
    end
  end

  // ************************************************************
  // wake-up latch
  // ************************************************************
  // a new event wins over an acknowledge in the same cycle
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      wake_q <= 1'b0;
    end else if (wake_event_in) begin
      wake_q <= 1'b1;
    end else if (intr_ack_in) begin
      wake_q <= 1'b0;
    end
  end

  // ************************************************************
  // mode sequencer
  // ************************************************************
  assign redirect = pend_q && wake_q && (tgt_q != PMC_ACTIVE);
  assign complete = pend_q && !redirect && clk_ok(tgt_q, hf_good_q, lf_good_q);

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      mode_q <= PMC_ACTIVE;
      tgt_q <= PMC_ACTIVE;
      pend_q <= 1'b0;
    end else if (pend_q) begin
      if (redirect) begin
        tgt_q <= PMC_ACTIVE;
      end else if (complete) begin
        mode_q <= tgt_q;
        pend_q <= 1'b0;
      end
    end else if (wake_q) begin
      if (mode_q != PMC_ACTIVE) begin
        tgt_q <= PMC_ACTIVE;
        pend_q <= 1'b1;
      end
    end else begin
      case (mode_q)
        PMC_ACTIVE: begin
          if (wait_exec_in && ctrl_q.wait_before_power_save) begin
            if (ctrl_q.halt_request) begin
              tgt_q <= PMC_HALT;
              pend_q <= 1'b1;
            end else if (ctrl_q.idle_request) begin
              tgt_q <= PMC_IDLE;
              pend_q <= 1'b1;
            end else if (ctrl_q.power_save_request) begin
              tgt_q <= PMC_PSAVE;
              pend_q <= 1'b1;
            end
          end else if (wr_csr && pwdata_in[PMC_BIT_PSM] && !pwdata_in[PMC_BIT_WBPS]
                       && !ctrl_q.power_save_request) begin
            tgt_q <= PMC_PSAVE;
            pend_q <= 1'b1;
          end
        end
        PMC_PSAVE: begin
          if (wait_exec_in && ctrl_q.halt_request) begin
            tgt_q <= PMC_HALT;
            pend_q <= 1'b1;
          end else if (wait_exec_in && ctrl_q.idle_request) begin
            tgt_q <= PMC_IDLE;
            pend_q <= 1'b1;
          end else if (wr_csr && !pwdata_in[PMC_BIT_PSM]) begin
            tgt_q <= PMC_ACTIVE;
            pend_q <= 1'b1;
          end
        end
        default: begin
          pend_q <= 1'b0;
        end
      endcase
    end
  end

  // ************************************************************
  // control/status register fields
  // ************************************************************
  // one process owns the whole register so each field has a single driver;
  // power_save_request follows the mode once a switch completes, and a
  // wake-up clears the requests, winning over a write in that cycle
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      ctrl_q.power_save_request <= 1'b0;
      ctrl_q.hf_osc_disable <= 1'b0;
      ctrl_q.idle_request <= 1'b0;
      ctrl_q.halt_request <= 1'b0;
      ctrl_q.wait_before_power_save <= 1'b0;
    end else begin
      if (wake_event_in) begin
        ctrl_q.power_save_request <= 1'b0;
      end else if (complete && tgt_q == PMC_PSAVE) begin
        ctrl_q.power_save_request <= 1'b1;
      end else if (complete && tgt_q == PMC_ACTIVE && mode_q == PMC_PSAVE) begin
        ctrl_q.power_save_request <= 1'b0;
      end else if (wr_csr && mode_q == PMC_ACTIVE && !pend_q) begin
        if (!pwdata_in[PMC_BIT_PSM]) begin
          ctrl_q.power_save_request <= 1'b0;
        end else if (pwdata_in[PMC_BIT_WBPS]) begin
          ctrl_q.power_save_request <= 1'b1;
        end
      end
      if (wake_event_in) begin
        ctrl_q.hf_osc_disable <= 1'b0;
        ctrl_q.idle_request <= 1'b0;
        ctrl_q.halt_request <= 1'b0;
      end else if (wr_csr) begin
        ctrl_q.hf_osc_disable <= pwdata_in[PMC_BIT_DHF];
        ctrl_q.idle_request <= pwdata_in[PMC_BIT_IDLE];
        ctrl_q.halt_request <= pwdata_in[PMC_BIT_HALT];
      end
      if (wr_csr) begin
        ctrl_q.wait_before_power_save <= pwdata_in[PMC_BIT_WBPS];
      end
    end
  end

  // ************************************************************
  // main oscillator control
  // ************************************************************
  // decided from the registered mode, so the oscillator stops only after
  // entry; a pending return to Active restarts it even if software forgot
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      stop_q <= 1'b0;
    end else if (pend_q && tgt_q == PMC_ACTIVE) begin
      stop_q <= 1'b0;
    end else if (mode_q == PMC_HALT) begin
      stop_q <= 1'b1;
    end else if (mode_q == PMC_PSAVE || mode_q == PMC_IDLE) begin
      stop_q <= ctrl_q.hf_osc_disable && xtal_s;
    end else begin
      stop_q <= 1'b0;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      mode_out <= PMC_ACTIVE;
      wake_pending_out <= 1'b0;
    end else begin
      mode_out <= mode_q;
      wake_pending_out <= wake_q;
    end
  end

  assign stop_main_osc_out = stop_q;
  assign prdata_out = prdata_q;
  assign pready_out = pready_q;
  assign pslverr_out = pslverr_q;

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);

  sequence s_exit_wait;
    pend_q && tgt_q == PMC_ACTIVE && !hf_good_q;
  endsequence

  sequence s_enter_low;
    mode_q == PMC_ACTIVE ##1 (mode_q == PMC_PSAVE || mode_q == PMC_IDLE);
  endsequence

  a_wake_clears_req: assert property (
    wake_event_in |=> !ctrl_q.power_save_request && !ctrl_q.hf_osc_disable
                      && !ctrl_q.idle_request && !ctrl_q.halt_request)
    else $error("wake-up did not clear the mode requests");

  a_active_needs_hf: assert property (
    (mode_q != PMC_ACTIVE ##1 mode_q == PMC_ACTIVE) |-> $past(hf_good_q))
    else $error("entered Active without a good fast clock");

  a_low_needs_lf: assert property (
    s_enter_low |-> $past(lf_good_q))
    else $error("entered Power Save or Idle without a good slow clock");

  a_exit_held: assert property (
    s_exit_wait |=> mode_q == $past(mode_q))
    else $error("return to Active did not wait for the fast clock");

  a_sleep_source: assert property (
    (mode_q != $past(mode_q) && (mode_q == PMC_IDLE || mode_q == PMC_HALT))
    |-> ($past(mode_q) == PMC_ACTIVE || $past(mode_q) == PMC_PSAVE))
    else $error("Idle or Halt entered from a sleep mode");

  a_osc_run_active: assert property (
    mode_q == PMC_ACTIVE |=> !stop_q)
    else $error("oscillator stopped in Active");

  a_osc_stop_halt: assert property (
    (mode_q == PMC_HALT && !pend_q) [*2] |-> stop_q)
    else $error("oscillator running in Halt");

  a_no_xtal_run: assert property (
    (!xtal_s && mode_q != PMC_HALT) |=> !stop_q)
    else $error("oscillator stopped without slow crystal outside Halt");

  a_wait_flag_now: assert property (
    (wr_csr && mode_q == PMC_ACTIVE && !pend_q && !wake_event_in
     && pwdata_in[PMC_BIT_PSM] && pwdata_in[PMC_BIT_WBPS]) |=> ctrl_q.power_save_request)
    else $error("power save request not set at once with wait flag");

  a_psm_deferred: assert property (
    (wr_csr && mode_q == PMC_ACTIVE && !pend_q && !ctrl_q.power_save_request
     && !wake_q && !wake_event_in && !wait_exec_in
     && pwdata_in[PMC_BIT_PSM] && !pwdata_in[PMC_BIT_WBPS] && !lf_good_q)
    |=> !ctrl_q.power_save_request && pend_q)
    else $error("power save request set before the switch completed");

  a_wake_latched: assert property (
    (wake_q && !intr_ack_in) |=> wake_q)
    else $error("wake-up lost before acknowledge");

  a_lf_select: assert property (
    ##1 lf_good_q == $past(slow_src_xtal_in ? slow_good_s : main_good))
    else $error("slow clock good does not follow the selected source");

  a_rsv_zero: assert property (
    pready_q |-> !prdata_q[PMC_BIT_RSV])
    else $error("reserved bit read as one");

endmodule : pmc_top
`default_nettype wire

// ==== tb/pmc_clk_model.sv ====
/*
  Model of the dual clock side: slow crystal detect pin and slow
  oscillator good level. Assumes crystal_fit_in is set by the bench.
*/
`timescale 1ns/1ps
`default_nettype none
module pmc_clk_model #(
  parameter int SLOW_START_NS = 300
) (
  // bench control
  input wire logic crystal_fit_in,
  // dual clock outputs
  output logic slow_osc_good_out,
  output logic slow_crystal_detect_out
);
  // ************************************************************
  // slow crystal
  // ************************************************************
  logic started_q;
  initial begin
    started_q = 1'h0;
    #SLOW_START_NS started_q = 1'h1;
  end
  // pin tied low when no crystal is fitted, never left floating
  assign slow_crystal_detect_out = crystal_fit_in;
  // good only once the crystal has had time to start
  assign slow_osc_good_out = crystal_fit_in & started_q;
endmodule : pmc_clk_model
`default_nettype wire

// ==== tb/power_mode_controller_test.sv ====
/*
  Bench of the power mode controller: APB tasks, WAIT, wake-up and
  acknowledge pulses, directed mode sequences with expected values.
  Assumes pmc_pkg, the design and pmc_clk_model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module power_mode_controller_test
  import pmc_pkg::*;
;
  // ************************************************************
  // signals and instances
  // ************************************************************
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [PMC_ADDR_W-1:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [2:0] ev = 3'h0;
  logic fit = 1'h0;
  logic src = 1'h0;
  logic [31:0] prdata, r;
  logic pready, perr, e, stop, wpend, sgood, sdet;
  pmc_mode_t mode;
  int fails = 0;
  int check_count = 0;

  always #2.5 clk = ~clk;

  // short settle count keeps each oscillator restart brief
  pmc_top #(.MAIN_GOOD_PRESET(14'h0010)) dut_u (
    .ref_clk_in(clk), .rst_in(rst), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(perr),
    .wait_exec_in(ev[0]), .wake_event_in(ev[1]), .intr_ack_in(ev[2]),
    .slow_src_xtal_in(src), .slow_osc_good_in(sgood),
    .slow_crystal_detect_in(sdet), .stop_main_osc_out(stop),
    .mode_out(mode), .wake_pending_out(wpend));

  pmc_clk_model clk_u (
    .crystal_fit_in(fit), .slow_osc_good_out(sgood), .slow_crystal_detect_out(sdet));

  // ************************************************************
  // tasks
  // ************************************************************
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    check_count++;
    if (g !== x) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [PMC_ADDR_W-1:0] a, input logic [7:0] d);
    int n;
    n = 0;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'h1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    r = prdata;
    e = perr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (pready !== 1'h1) begin
      fails++;
      results();
    end
    @(posedge clk);
  endtask : apb

  task automatic wr(input logic [7:0] d);
    apb(1'h1, PMC_OFS_CSR, d);
  endtask : wr

  task automatic rd(input logic [7:0] x);
    apb(1'h0, PMC_OFS_CSR, 8'h00);
    chk(r, {24'h000000, x});
  endtask : rd

  // polls both clock good bits, as software must before sleeping
  task automatic good;
    int n;
    n = 0;
    do begin
      apb(1'h0, PMC_OFS_CSR, 8'h00);
      n++;
    end while (r[7:6] !== 2'h3 && n < 100);
    chk({30'h0, r[7:6]}, 32'h3);
  endtask : good

  task automatic wmode(input pmc_mode_t m);
    int n;
    n = 0;
    while (mode !== m && n < 200) begin
      @(posedge clk);
      n++;
    end
    chk({30'h0, mode}, {30'h0, m});
  endtask : wmode

  // bit 0 wait, bit 1 wake-up, bit 2 acknowledge
  task automatic pulse(input logic [2:0] p);
    ev <= p;
    @(posedge clk);
    ev <= 3'h0;
    repeat (2) @(posedge clk);
  endtask : pulse

  // ************************************************************
  // sequence
  // ************************************************************
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'h0;
    rd(8'h00);
    good();
    apb(1'h0, 12'h004, 8'h00);
    chk({31'h0, e}, 32'h1);
    chk(r, PMC_RD_ZERO);
    wr(8'hD0);
    rd(8'hC0);
    wr(8'h04);
    pulse(3'h1);
    repeat (6) @(posedge clk);
    chk({30'h0, mode}, 32'h0);
    wr(8'h01);
    wmode(PMC_PSAVE);
    rd(8'hC1);
    wr(8'h03);
    repeat (8) @(posedge clk);
    chk({31'h0, stop}, 32'h0);
    fit <= 1'h1;
    repeat (10) @(posedge clk);
    chk({31'h0, stop}, 32'h1);
    apb(1'h0, PMC_OFS_CSR, 8'h00);
    chk({31'h0, r[6]}, 32'h0);
    wr(8'h01);
    good();
    wr(8'h00);
    wmode(PMC_ACTIVE);
    rd(8'hC0);
    wr(8'h24);
    pulse(3'h1);
    wmode(PMC_IDLE);
    pulse(3'h2);
    wmode(PMC_ACTIVE);
    chk({31'h0, wpend}, 32'h1);
    pulse(3'h4);
    chk({31'h0, wpend}, 32'h0);
    good();
    rd(8'hE0);
    wr(8'h28);
    pulse(3'h1);
    wmode(PMC_HALT);
    chk({31'h0, stop}, 32'h1);
    pulse(3'h2);
    wmode(PMC_ACTIVE);
    pulse(3'h4);
    good();
    rd(8'hE0);
    wr(8'h23);
    rd(8'hE3);
    chk({30'h0, mode}, 32'h0);
    chk({31'h0, stop}, 32'h0);
    pulse(3'h1);
    wmode(PMC_PSAVE);
    repeat (4) @(posedge clk);
    chk({31'h0, stop}, 32'h1);
    pulse(3'h2);
    wmode(PMC_ACTIVE);
    pulse(3'h4);
    good();
    rd(8'hE0);
    src <= 1'h1;
    fit <= 1'h0;
    repeat (8) @(posedge clk);
    rd(8'h60);
    wr(8'h01);
    repeat (10) @(posedge clk);
    chk({30'h0, mode}, 32'h0);
    rd(8'h40);
    fit <= 1'h1;
    wmode(PMC_PSAVE);
    rd(8'hC1);
    results();
  end
endmodule : power_mode_controller_test
`default_nettype wire
